//--- hdl/otc_calibrator.sv
// Purpose: Calibrates the fast internal oscillator trim against the crystal sub-clock.
// Assumes: Oscillator and sub-clock arrive as levels synchronous to clk.
// Notes: The sub-clock and oscillator are sampled; clk must be well above the oscillator rate.
`timescale 1ns/10ps
`default_nettype none
`include "otc_map.svh"
module otc_calibrator (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Clock sources being observed.
  input wire logic fast_internal_osc,
  input wire logic sub_clock,
  // One-second periodic tick, one-cycle pulse.
  input wire logic sec_tick,
  // Active oscillator frequency setting.
  input wire otc_pkg::otc_freq_t freq_sel,
  // Trim code outputs.
  output logic [`OTC_TRIM_W-1:0] osc_trim_code_32m,
  output logic [`OTC_TRIM_W-1:0] osc_trim_code_set,
  output logic [4*`OTC_TRIM_W-1:0] osc_trim_code_all,
  // Status.
  output otc_pkg::otc_evt_t evt,
  output logic [`OTC_CNT_W-1:0] last_average,
  output logic busy
);

  // Theoretical count for the selected frequency.
  function automatic logic [`OTC_CNT_W-1:0] theo_count(input otc_pkg::otc_freq_t f);
    case (f)
      otc_pkg::FREQ_32M: theo_count = `OTC_THEO_32M;
      otc_pkg::FREQ_36M: theo_count = `OTC_THEO_36M;
      otc_pkg::FREQ_40M: theo_count = `OTC_THEO_40M;
      default: theo_count = `OTC_THEO_50M;
    endcase
  endfunction : theo_count

  // Edge detector state on the raw inputs.
  logic osc_prev_q;
  logic sub_prev_q;
  // Divider counters.
  logic [`OTC_OSC_DIV_W-1:0] osc_div_q;
  logic [`OTC_REF_DIV_W-1:0] ref_div_q;
  // Sequencer.
  otc_pkg::otc_state_t state_q;
  logic [1:0] meas_idx_q;
  logic [`OTC_CNT_W-1:0] edge_cnt_q;
  logic [`OTC_CNT_W+1:0] acc_q;
  // Trim code store, one per frequency.
  otc_pkg::otc_trim_t trim_q [0:3];
  // Derived strobes and values.
  logic osc_tick;
  logic ref_rise;
  logic [`OTC_CNT_W+1:0] acc_sum;
  logic [`OTC_CNT_W-1:0] avg;
  logic [`OTC_CNT_W-1:0] theo;
  logic hi_out;
  logic lo_out;
  logic step_down; // Average high and the code can still go down.
  logic step_up; // Average low and the code can still go up.

  // A divided-clock edge is one full wrap of each divider.
  assign osc_tick = fast_internal_osc && !osc_prev_q && (osc_div_q == 5'h1F);
  assign ref_rise = sub_clock && !sub_prev_q && (ref_div_q == 10'h3FF);
  assign acc_sum = acc_q + {2'h0, edge_cnt_q};
  assign avg = acc_sum[`OTC_CNT_W+1:2];
  assign theo = theo_count(freq_sel);
  // Comparison is widened so that theo + tolerance and avg + tolerance cannot overflow.
  assign hi_out = ({1'b0, avg} >= ({1'b0, theo} + {1'b0, `OTC_TOLERANCE}));
  assign lo_out = ({1'b0, avg} + {1'b0, `OTC_TOLERANCE}) <= {1'b0, theo};
  // A step event reports a step really taken, so a saturated code raises none.
  assign step_down = hi_out && (trim_q[freq_sel] != `OTC_TRIM_MIN);
  assign step_up = lo_out && (trim_q[freq_sel] != `OTC_TRIM_MAX);

  // Edge history of the sampled clocks.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Track the pins in reset, so a high pin gives no false edge at release.
      osc_prev_q <= fast_internal_osc;
      sub_prev_q <= sub_clock;
    end
    else
    begin
      osc_prev_q <= fast_internal_osc;
      sub_prev_q <= sub_clock;
    end
  end

  // Free-running dividers; they keep running between rounds so the phase is stable.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      osc_div_q <= 5'h00;
      ref_div_q <= 10'h000;
    end
    else
    begin
      if (fast_internal_osc && !osc_prev_q)
      begin
        osc_div_q <= osc_div_q + 5'h01;
      end
      if (sub_clock && !sub_prev_q)
      begin
        ref_div_q <= ref_div_q + 10'h001;
      end
    end
  end

  // Calibration sequencer: arm on a tick, measure four windows, adjust, then wait.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= otc_pkg::ST_IDLE;
      meas_idx_q <= 2'h0;
      edge_cnt_q <= '0;
      acc_q <= '0;
    end
    else
    begin
      case (state_q)
        otc_pkg::ST_IDLE:
        begin
          // Idle doubles as the stabilisation wait after a trim change.
          if (sec_tick)
          begin
            state_q <= otc_pkg::ST_ARM;
            meas_idx_q <= 2'h0;
            acc_q <= '0;
          end
        end
        otc_pkg::ST_ARM:
        begin
          // Wait for the first reference rising edge to open the window.
          if (ref_rise)
          begin
            state_q <= otc_pkg::ST_MEAS;
            edge_cnt_q <= {16'h0000, osc_tick};
          end
        end
        otc_pkg::ST_MEAS:
        begin
          if (ref_rise)
          begin
            // The closing edge opens the next window back to back.
            acc_q <= acc_sum;
            meas_idx_q <= meas_idx_q + 2'h1;
            if (meas_idx_q == 2'h3)
            begin
              // Last window: clear the count so the adjust-cycle sum holds four windows only.
              state_q <= otc_pkg::ST_ADJ;
              edge_cnt_q <= '0;
            end
            else
            begin
              edge_cnt_q <= {16'h0000, osc_tick};
            end
          end
          else if (osc_tick && (edge_cnt_q != 17'h1FFFF))
          begin
            // Count saturates so a stuck reference cannot wrap it.
            edge_cnt_q <= edge_cnt_q + 17'h00001;
          end
        end
        default:
        begin
          // Adjustment applied this cycle; counting is stopped.
          state_q <= otc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Trim codes; only the active frequency's code moves, and it saturates.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        trim_q[i] <= `OTC_TRIM_RESET;
      end
    end
    else if (state_q == otc_pkg::ST_ADJ)
    begin
      if (hi_out && (trim_q[freq_sel] != `OTC_TRIM_MIN))
      begin
        trim_q[freq_sel] <= trim_q[freq_sel] - 8'h01;
      end
      else if (lo_out && (trim_q[freq_sel] != `OTC_TRIM_MAX))
      begin
        trim_q[freq_sel] <= trim_q[freq_sel] + 8'h01;
      end
      // Inside the band the code is left alone.
    end
  end

  // Registered status and event pulses.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      evt <= '0;
      last_average <= '0;
    end
    else
    begin
      evt.meas_end <= (state_q == otc_pkg::ST_MEAS) && ref_rise;
      evt.trim_down <= (state_q == otc_pkg::ST_ADJ) && step_down;
      evt.trim_up <= (state_q == otc_pkg::ST_ADJ) && step_up;
      evt.round_done <= (state_q == otc_pkg::ST_ADJ);
      if (state_q == otc_pkg::ST_MEAS && ref_rise && meas_idx_q == 2'h3)
      begin
        last_average <= avg;
      end
    end
  end

  assign osc_trim_code_32m = trim_q[0];
  assign osc_trim_code_set = trim_q[freq_sel];
  assign osc_trim_code_all = {trim_q[3], trim_q[2], trim_q[1], trim_q[0]};
  assign busy = (state_q != otc_pkg::ST_IDLE);

endmodule : otc_calibrator
`default_nettype wire

//--- hdl/otc_map.svh
// Purpose: Constants for the oscillator trim calibrator.
// Assumes: Included by its bare name from the package and the design file.
// Notes: Definitions only.
`ifndef OTC_MAP_SVH
`define OTC_MAP_SVH
`define OTC_OSC_DIV 32
`define OTC_REF_DIV 1024
`define OTC_OSC_DIV_W 5
`define OTC_REF_DIV_W 10
`define OTC_MEAS_PER_ROUND 4
`define OTC_TOLERANCE 17'h00100
`define OTC_THEO_32M 17'h07A12
`define OTC_THEO_36M 17'h08CA0
`define OTC_THEO_40M 17'h09896
`define OTC_THEO_50M 17'h0BEBC
`define OTC_TRIM_W 8
`define OTC_TRIM_MAX 8'hFF
`define OTC_TRIM_MIN 8'h00
`define OTC_TRIM_RESET 8'h80
`define OTC_CNT_W 17
`endif

//--- hdl/otc_pkg.sv
// Purpose: Types for the oscillator trim calibrator.
// Assumes: otc_map.svh provides widths.
// Notes: Nothing here is imported; users write otc_pkg::name.
`include "otc_map.svh"
package otc_pkg;
  // Oscillator frequency setting that selects the active trim code.
  typedef enum logic [1:0] {FREQ_32M, FREQ_36M, FREQ_40M, FREQ_50M} otc_freq_t;
  // Calibration sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_MEAS, ST_ADJ} otc_state_t;
  // One trim code.
  typedef logic [`OTC_TRIM_W-1:0] otc_trim_t;
  // Event outputs that travel together.
  typedef struct packed {
    logic meas_end;
    logic trim_up;
    logic trim_down;
    logic round_done;
  } otc_evt_t;
endpackage : otc_pkg

//--- sim/otc_clk_model.sv
// Purpose: Stand-in for the oscillator and the crystal sub-clock.
// Assumes: Runs off the bench clock.
// Notes: Fixed ratio, so every window holds 16 divided edges.
`timescale 1ns/10ps
`default_nettype none
module otc_clk_model (
  // Bench clock.
  input wire logic clk,
  // Sources seen by the calibrator.
  output logic fast_internal_osc,
  output logic sub_clock
);
  logic [1:0] cnt_q = 2'h0; // Shared phase counter.
  // Both run free, as real sources do, and move off the sampling edge.
  always @(negedge clk)
  begin
    cnt_q <= cnt_q + 2'h1;
    fast_internal_osc <= cnt_q[1];
    sub_clock <= cnt_q[0];
  end
endmodule : otc_clk_model
`default_nettype wire

//--- sim/otc_calibrator_assertions.sv
// Purpose: Port checks for the calibrator.
// Assumes: Bound to every calibrator instance.
// Notes: Theoretical counts are kept here, apart from the design.
`timescale 1ns/10ps
`default_nettype none
module otc_calibrator_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Inputs.
  input wire otc_pkg::otc_freq_t freq_sel,
  input wire logic sec_tick,
  // Outputs.
  input wire logic [7:0] osc_trim_code_32m,
  input wire logic [7:0] osc_trim_code_set,
  input wire logic [31:0] osc_trim_code_all,
  input wire otc_pkg::otc_evt_t evt,
  input wire logic [16:0] last_average,
  input wire logic busy
);
  logic [17:0] theo; // Count expected for the active setting.
  assign theo = freq_sel[1] ? (freq_sel[0] ? 18'h0BEBC : 18'h09896)
                            : (freq_sel[0] ? 18'h08CA0 : 18'h07A12);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_tick_busy: assert property (!busy && sec_tick |=> busy)
    else $error("tick did not start a round");
  a_meas_busy: assert property (evt.meas_end |-> busy)
    else $error("measurement outside a round");
  a_done_idle: assert property (evt.round_done |-> !busy && !evt.meas_end)
    else $error("still measuring after round");
  a_up_step: assert property (evt.trim_up |-> osc_trim_code_set == $past(osc_trim_code_set) + 8'h01)
    else $error("up step not one");
  a_trim_still: assert property (!evt.round_done |-> $stable(osc_trim_code_all))
    else $error("trim moved outside adjustment");
  a_low_up: assert property (evt.round_done && {1'b0, last_average} + 18'h00100 <= theo
    |-> evt.trim_up || osc_trim_code_set == 8'hFF)
    else $error("low average not stepped up");
  a_high_down: assert property (evt.round_done && {1'b0, last_average} >= theo + 18'h00100
    |-> evt.trim_down || osc_trim_code_set == 8'h00)
    else $error("high average not stepped down");
  a_band_hold: assert property (evt.round_done && !evt.trim_up && !evt.trim_down
    |-> $stable(osc_trim_code_all))
    else $error("trim moved inside band");
  a_set_mux: assert property (osc_trim_code_set == osc_trim_code_all[{freq_sel, 3'h0} +: 8])
    else $error("active code mismatch");
  c_meas: cover property (evt.meas_end);
  c_round: cover property (evt.round_done);
  c_up: cover property (evt.trim_up);
endmodule : otc_calibrator_chk
bind otc_calibrator otc_calibrator_chk chk_u (.clk, .srst, .freq_sel, .sec_tick,
  .osc_trim_code_32m, .osc_trim_code_set, .osc_trim_code_all, .evt, .last_average, .busy);
`default_nettype wire

//--- sim/tb.sv
// Purpose: Self-checking bench for the calibrator.
// Assumes: Model gives osc at clk/4 and sub-clock at clk/2.
// Notes: Fixed model ratio keeps the average at 16, so only up steps are reachable.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sec_tick = 1'b0;
  logic osc, sub, busy;
  otc_pkg::otc_freq_t freq_sel = otc_pkg::FREQ_32M;
  otc_pkg::otc_evt_t evt;
  logic [7:0] c32, cset;
  logic [31:0] call;
  logic [16:0] avg;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  // Clock of 200 MHz.
  always #2.5 clk = ~clk;
  otc_clk_model mdl_u (.clk, .fast_internal_osc(osc), .sub_clock(sub));
  otc_calibrator dut_u (.clk, .srst, .fast_internal_osc(osc), .sub_clock(sub), .sec_tick,
    .freq_sel, .osc_trim_code_32m(c32), .osc_trim_code_set(cset),
    .osc_trim_code_all(call), .evt, .last_average(avg), .busy);
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One round with a slow oscillator: average 16, so the active code steps up.
  task automatic t_round(input otc_pkg::otc_freq_t f, input logic [31:0] e_all);
    int n;
    int i;
    n = 0;
    @(negedge clk) freq_sel = f;
    sec_tick = 1'b1;
    @(negedge clk) sec_tick = 1'b0;
    chk("busy", 1, busy);
    @(negedge clk) sec_tick = 1'b1;
    @(negedge clk) sec_tick = 1'b0;
    for (i = 0; i < 12000 && evt.round_done !== 1'b1; i++)
    begin
      @(negedge clk);
      n += evt.meas_end;
    end
    chk("meas_end", 4, n);
    chk("average", 16, avg);
    chk("round_done", 1, evt.round_done);
    chk("trim_up", 1, evt.trim_up);
    chk("trim_down", 0, evt.trim_down);
    chk("code set", e_all[8*f +: 8], cset);
    chk("code 32m", e_all[7:0], c32);
    chk("codes", e_all, call);
    chk("busy", 0, busy);
    for (i = 0; i < 2100; i++)
    begin
      @(negedge clk);
      n += evt.meas_end;
    end
    chk("quiet", 4, n);
  endtask : t_round
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("reset codes", 32'h80808080, call);
    chk("reset avg", 0, avg);
    t_round(otc_pkg::FREQ_32M, 32'h80808081);
    t_round(otc_pkg::FREQ_50M, 32'h81808081);
    report_and_stop();
  end
  // A hang is cut off well past two rounds.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      report_and_stop();
    end
  end
endmodule : tb
`default_nettype wire
